/* logic/gpio_bank_irq_pad_mux.sv */
// gpio bank top: function mux, pin interrupts, pad control, apb registers
//==============================================================
// Contract
// - flash pins: select 0 flash, 5 software
// - software drives if selected; input always routed
// - flash pins map high bits, clock first
// - four interrupt conditions on every pin
// - level conditions follow pin, never stored
// - edges latched until software writes clear
// - three destinations: enable, status, force each
// - dormant wake line needs no running clock; levels and forces reach it unclocked, edge detection needs the clock
// - one ORed line per bank and destination
// - oe, out, in pass through the mux
// - pad bit forces output driver off
// - drive strength field with four settings
// - schmitt, slew, pulls, input enable per pad
// - per-bank low-voltage select, default high range
// - reset: input enabled, output kill clear
// - user pins: status then control, then interrupts
module gpio_bank_irq_pad_mux
   import gpio_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // user bank, software io and peripheral matrix
   input wire logic [NUSR-1:0] swOut,
   input wire logic [NUSR-1:0] swOe,
   output logic [NUSR-1:0] swIn,
   input wire logic [NUSR-1:0] perOut,
   input wire logic [NUSR-1:0] perOe,
   output logic [NUSR-1:0] perIn,
   output logic [5*NUSR-1:0] userFsel,
   // flash bank, software io high bank and flash serial path
   input wire logic [NFL-1:0] swHiOut,
   input wire logic [NFL-1:0] swHiOe,
   output logic [NFL-1:0] swHiIn,
   input wire logic [NFL-1:0] flOut,
   input wire logic [NFL-1:0] flOe,
   output logic [NFL-1:0] flIn,
   // pads
   input wire logic [NPIN-1:0] padIn,
   output logic [NPIN-1:0] padOut,
   output logic [NPIN-1:0] padOe,
   output logic [2*NPIN-1:0] padDrive,
   output logic [NPIN-1:0] padSlewFast,
   output logic [NPIN-1:0] padSchmitt,
   output logic [NPIN-1:0] padPullUp,
   output logic [NPIN-1:0] padPullDown,
   output logic [NPIN-1:0] padInEn,
   output logic [1:0] padLowVolt,
   // interrupts
   output logic [2*NDEST-1:0] irqLine,
   output logic irq
);
   //==============================================================
   // state
   logic [CT_W-1:0] ctrl_r [NPIN];
   logic [PAD_W-1:0] padCtl_r [NPIN];
   logic [1:0] vsel_r;
   logic [1:0] evt_r;
   logic [1:0] mask_r;
   logic [31:0] prdata_r;
   logic hit_r;

   //==============================================================
   // decode results
   logic wr;
   logic rd;
   logic rdHit;
   logic maskWe;
   logic evtRd;
   logic [31:0] rdVal;
   logic [NPIN-1:0] ctrlWe;
   logic [NPIN-1:0] padWe;
   logic [NPIN-1:0] primOut;
   logic [NPIN-1:0] primOe;
   logic [NPIN-1:0] swO;
   logic [NPIN-1:0] swE;
   logic [NPIN-1:0] inSel;
   logic [1:0] vselWe;

   irq_bank_if #(.N(NUSR)) uI ();
   irq_bank_if #(.N(NFL)) fI ();

   // {hit, word index} of an address inside a run of cnt words
   function automatic logic [6:0] slot(input logic [11:0] a, input logic [11:0] base,
      input int cnt);
      logic [11:0] d;
      d = a - base;
      slot = '0;
      if (a >= base && d[1:0] == 2'h0 && int'(d[11:2]) < cnt) slot = {1'b1, d[7:2]};
   endfunction

   //==============================================================
   // apb decode
   assign wr = psel & penable & pwrite;
   assign rd = psel & penable & ~pwrite;

   always_comb begin
      logic [6:0] s;
      int p;
      int d;
      int k;
      int w;
      s = '0;
      p = 0;
      d = 0;
      k = 0;
      w = 0;
      rdHit = 1'b0;
      rdVal = '0;
      ctrlWe = '0;
      padWe = '0;
      vselWe = '0;
      maskWe = 1'b0;
      evtRd = 1'b0;
      uI.wrIntr = 1'b0;
      uI.wrEn = '0;
      uI.wrForce = '0;
      uI.wrWord = '0;
      uI.wrData = pwdata;
      fI.wrIntr = 1'b0;
      fI.wrEn = '0;
      fI.wrForce = '0;
      fI.wrWord = '0;
      fI.wrData = pwdata;
      // status word then control word, pin by pin
      s = slot(paddr, A_USR_IO, 2 * NUSR);
      if (s[6]) begin
         p = int'(s[5:1]);
         rdHit = 1'b1;
         rdVal = s[0] ? 32'(ctrl_r[p]) : {29'h0, inSel[p], padOe[p], padOut[p]};
         ctrlWe[p] = wr & s[0];
      end
      s = slot(paddr, A_FL_IO, 2 * NFL);
      if (s[6]) begin
         p = NUSR + int'(s[5:1]);
         rdHit = 1'b1;
         rdVal = s[0] ? 32'(ctrl_r[p]) : {29'h0, inSel[p], padOe[p], padOut[p]};
         ctrlWe[p] = wr & s[0];
      end
      // raw words right after the pin registers
      s = slot(paddr, A_USR_INTR, 4);
      if (s[6]) begin
         rdHit = 1'b1;
         rdVal = uI.raw[32*int'(s[1:0]) +: 32];
         uI.wrIntr = wr;
         uI.wrWord = s[1:0];
      end
      s = slot(paddr, A_FL_INTR, 1);
      if (s[6]) begin
         rdHit = 1'b1;
         rdVal = fI.raw;
         fI.wrIntr = wr;
      end
      // enable, force, status words per destination
      s = slot(paddr, A_USR_DEST, 12 * NDEST);
      if (s[6]) begin
         p = int'(s[5:0]);
         d = p / 12;
         k = (p % 12) / 4;
         w = p % 4;
         rdHit = 1'b1;
         uI.wrWord = 2'(w);
         if (k == 0) rdVal = uI.en[d][32*w +: 32];
         else if (k == 1) rdVal = uI.frc[d][32*w +: 32];
         else rdVal = uI.stat[d][32*w +: 32];
         uI.wrEn[d] = wr && k == 0;
         uI.wrForce[d] = wr && k == 1;
      end
      s = slot(paddr, A_FL_DEST, 3 * NDEST);
      if (s[6]) begin
         p = int'(s[5:0]);
         d = p / 3;
         k = p % 3;
         rdHit = 1'b1;
         if (k == 0) rdVal = fI.en[d];
         else if (k == 1) rdVal = fI.frc[d];
         else rdVal = fI.stat[d];
         fI.wrEn[d] = wr && k == 0;
         fI.wrForce[d] = wr && k == 1;
      end
      // threshold select word, then one word per pad
      s = slot(paddr, A_UPAD, NUSR + 1);
      if (s[6]) begin
         p = int'(s[5:0]);
         rdHit = 1'b1;
         if (p == 0) begin
            rdVal = 32'(vsel_r[0]);
            vselWe[0] = wr;
         end else begin
            rdVal = 32'(padCtl_r[p-1]);
            padWe[p-1] = wr;
         end
      end
      s = slot(paddr, A_FPAD, NFL + 1);
      if (s[6]) begin
         p = int'(s[5:0]);
         rdHit = 1'b1;
         if (p == 0) begin
            rdVal = 32'(vsel_r[1]);
            vselWe[1] = wr;
         end else begin
            rdVal = 32'(padCtl_r[NUSR+p-1]);
            padWe[NUSR+p-1] = wr;
         end
      end
      s = slot(paddr, A_EVT, 2);
      if (s[6]) begin
         rdHit = 1'b1;
         if (s[0]) begin
            rdVal = 32'(mask_r);
            maskWe = wr;
         end else begin
            rdVal = 32'(evt_r);
            evtRd = rd;
         end
      end
   end

   // read data is captured in the setup cycle so it leaves a flop
   always_ff @(posedge clk) begin
      if (rst) begin
         prdata_r <= '0;
         hit_r <= 1'b0;
      end else if (psel && !penable) begin
         prdata_r <= rdVal;
         hit_r <= rdHit;
      end
   end

   assign prdata = prdata_r;
   assign pready = psel & penable;
   assign pslverr = psel & penable & ~hit_r;

   //==============================================================
   // control registers
   always_ff @(posedge clk) begin
      for (int i = 0; i < NPIN; i++) begin
         if (rst) ctrl_r[i] <= (i < NUSR) ? USR_CTRL_RST : FL_CTRL_RST;
         else if (ctrlWe[i]) ctrl_r[i] <= pwdata[CT_W-1:0];
      end
   end

   // pads leave reset with input on, kill off
   always_ff @(posedge clk) begin
      for (int i = 0; i < NPIN; i++) begin
         if (rst) padCtl_r[i] <= PAD_RST;
         else if (padWe[i]) padCtl_r[i] <= pwdata[PAD_W-1:0];
      end
   end

   // one select per bank, 1 means low voltage
   always_ff @(posedge clk) begin
      for (int i = 0; i < 2; i++) begin
         if (rst) vsel_r[i] <= VSEL_RST;
         else if (vselWe[i]) vsel_r[i] <= pwdata[0];
      end
   end

   //==============================================================
   // summary interrupt: bit 0 user edge, bit 1 flash edge
   always_ff @(posedge clk) begin
      if (rst) mask_r <= '0;
      else if (maskWe) mask_r <= pwdata[1:0];
   end

   // read clears only what was returned; a new edge wins
   always_ff @(posedge clk) begin
      if (rst) evt_r <= '0;
      else evt_r <= (evt_r & ~(evtRd ? prdata_r[1:0] : 2'h0)) | {fI.edgeSet, uI.edgeSet};
   end

   assign irq = |(evt_r & mask_r);

   //==============================================================
   // pin muxes and pad outputs
   assign primOut = {flOut, perOut};
   assign primOe = {flOe, perOe};
   assign swO = {swHiOut, swOut};
   assign swE = {swHiOe, swOe};

   for (genvar g = 0; g < NPIN; g++) begin : gPin
      pad_mux #(.ANY_PRIM(g < NUSR)) uMux (
         .ctrl(ctrl_r[g]),
         .padCtl(padCtl_r[g]),
         .primOut(primOut[g]),
         .primOe(primOe[g]),
         .swOut(swO[g]),
         .swOe(swE[g]),
         .inSel(inSel[g]),
         .padIn(padIn[g]),
         .padOut(padOut[g]),
         .padOe(padOe[g])
      );
      assign padDrive[2*g +: 2] = padCtl_r[g][PAD_DRV +: 2];
      // remaining pad controls from the register
      assign padSlewFast[g] = padCtl_r[g][PAD_SLEW];
      assign padSchmitt[g] = padCtl_r[g][PAD_SCHMITT];
      assign padPullUp[g] = padCtl_r[g][PAD_PU];
      assign padPullDown[g] = padCtl_r[g][PAD_PD];
      assign padInEn[g] = padCtl_r[g][PAD_IE];
      odKill_a: assert property (@(posedge clk) disable iff (rst)
         padCtl_r[g][PAD_OD] |-> !padOe[g])
         else $error("pad driver on while killed");
   end

   for (genvar g = 0; g < NUSR; g++) begin : gSel
      assign userFsel[5*g +: 5] = ctrl_r[g][CT_FSEL +: 5];
   end

   // inputs go back whatever is selected
   assign swIn = inSel[NUSR-1:0];
   assign perIn = inSel[NUSR-1:0];
   // flash pins in order clock, select, data 0..3
   assign swHiIn = inSel[NPIN-1:NUSR];
   assign flIn = inSel[NPIN-1:NUSR];
   assign padLowVolt = vsel_r;

   //==============================================================
   // interrupt banks
   assign uI.level = inSel[NUSR-1:0];
   assign fI.level = inSel[NPIN-1:NUSR];

   gpio_irq_bank #(.N(NUSR)) uUsrIrq (
      .clk(clk),
      .rst(rst),
      .b(uI.bank)
   );

   gpio_irq_bank #(.N(NFL)) uFlIrq (
      .clk(clk),
      .rst(rst),
      .b(fI.bank)
   );

   assign irqLine = {fI.line, uI.line};

   //==============================================================
   // checks
   flashPrim_a: assert property (@(posedge clk) disable iff (rst)
      ctrl_r[NUSR] == FL_CTRL_RST && !padCtl_r[NUSR][PAD_OD]
      |-> padOut[NUSR] == flOut[0] && padOe[NUSR] == flOe[0])
      else $error("flash clock pin not on flash path");
   swDrive_a: assert property (@(posedge clk) disable iff (rst)
      ctrl_r[NUSR] == CT_W'(FN_SW) |-> padOut[NUSR] == swHiOut[0])
      else $error("software io not driving selected pin");
   swInput_a: assert property (@(posedge clk) disable iff (rst)
      ctrl_r[NUSR][CT_IN +: 2] == OV_NORM && padCtl_r[NUSR][PAD_IE]
      |-> swHiIn[0] == padIn[NUSR])
      else $error("pin input not routed to software io");
   resetPad_a: assert property (@(posedge clk)
      rst |=> padInEn == '1 && padCtl_r[0][PAD_OD] == 1'b0)
      else $error("pad not ready after reset");
   vselWrite_a: assert property (@(posedge clk) disable iff (rst)
      wr && paddr == A_UPAD && pwdata[0] |=> padLowVolt[0] ##1 padLowVolt[0] || !wr)
      else $error("threshold select not taken");
   evtSet_a: assert property (@(posedge clk) disable iff (rst)
      uI.edgeSet |=> evt_r[0])
      else $error("edge event lost");
   irqOut_a: assert property (@(posedge clk) disable iff (rst)
      maskWe && pwdata[0] && evt_r[0] && !evtRd |=> irq)
      else $error("unmasked event without interrupt");
endmodule

/* pkg/gpio_pkg.sv */
// shared constants of the gpio bank: sizes, fields, reset values, register map
package gpio_pkg;
   //==========================================================
   // bank sizes
   localparam int NUSR = 30;
   localparam int NFL = 6;
   localparam int NPIN = NUSR + NFL;
   localparam int NDEST = 3;
   //==========================================================
   // function selects
   localparam logic [4:0] FN_PRIM = 5'h00;
   localparam logic [4:0] FN_SW = 5'h05;
   localparam logic [4:0] FN_NULL = 5'h1f;
   //==========================================================
   // io control word: select and three overrides
   localparam int CT_FSEL = 0;
   localparam int CT_OUT = 5;
   localparam int CT_OE = 7;
   localparam int CT_IN = 9;
   localparam int CT_W = 11;
   localparam logic [10:0] USR_CTRL_RST = 11'h01f;
   localparam logic [10:0] FL_CTRL_RST = 11'h000;
   localparam logic [1:0] OV_NORM = 2'h0;
   localparam logic [1:0] OV_INV = 2'h1;
   localparam logic [1:0] OV_LOW = 2'h2;
   localparam logic [1:0] OV_HIGH = 2'h3;
   //==========================================================
   // pad control word; drive 0..3 is 2, 4, 8, 12 mA
   localparam int PAD_SLEW = 0;
   localparam int PAD_SCHMITT = 1;
   localparam int PAD_PD = 2;
   localparam int PAD_PU = 3;
   localparam int PAD_DRV = 4;
   localparam int PAD_IE = 6;
   localparam int PAD_OD = 7;
   localparam int PAD_W = 8;
   localparam logic [7:0] PAD_RST = 8'h56;
   localparam logic VSEL_RST = 1'b0;
   //==========================================================
   // interrupt bits within a pin nibble
   localparam int IRQ_LOW = 0;
   localparam int IRQ_HIGH = 1;
   localparam int IRQ_FALL = 2;
   localparam int IRQ_RISE = 3;
   //==========================================================
   // byte addresses
   localparam logic [11:0] A_USR_IO = 12'h000;
   localparam logic [11:0] A_USR_INTR = 12'h0f0;
   localparam logic [11:0] A_USR_DEST = 12'h100;
   localparam logic [11:0] A_FL_IO = 12'h200;
   localparam logic [11:0] A_FL_INTR = 12'h230;
   localparam logic [11:0] A_FL_DEST = 12'h234;
   localparam logic [11:0] A_UPAD = 12'h300;
   localparam logic [11:0] A_FPAD = 12'h380;
   localparam logic [11:0] A_EVT = 12'h3f0;
endpackage

/* pkg/irq_bank_if.sv */
// register-side link between the top and one interrupt bank
interface irq_bank_if #(parameter int N = 8);
   localparam int RW = 32 * ((N + 7) / 8);
   logic [N-1:0] level;
   logic wrIntr;
   logic [2:0] wrEn;
   logic [2:0] wrForce;
   logic [1:0] wrWord;
   logic [31:0] wrData;
   logic [RW-1:0] raw;
   logic [RW-1:0] en [3];
   logic [RW-1:0] frc [3];
   logic [RW-1:0] stat [3];
   logic [2:0] line;
   logic edgeSet;
   modport ctl (output level, wrIntr, wrEn, wrForce, wrWord, wrData,
      input raw, en, frc, stat, line, edgeSet);
   modport bank (input level, wrIntr, wrEn, wrForce, wrWord, wrData,
      output raw, en, frc, stat, line, edgeSet);
endinterface

/* logic/pad_mux.sv */
// one pin: function select, overrides and output kill
module pad_mux
   import gpio_pkg::*;
#(
   parameter bit ANY_PRIM = 1'b0
) (
   // control
   input wire logic [CT_W-1:0] ctrl,
   input wire logic [PAD_W-1:0] padCtl,
   // function side
   input wire logic primOut,
   input wire logic primOe,
   input wire logic swOut,
   input wire logic swOe,
   output logic inSel,
   // pad side
   input wire logic padIn,
   output logic padOut,
   output logic padOe
);
   function automatic logic ovr(input logic v, input logic [1:0] m);
      unique case (m)
         OV_NORM: ovr = v;
         OV_INV: ovr = ~v;
         OV_LOW: ovr = 1'b0;
         OV_HIGH: ovr = 1'b1;
      endcase
   endfunction

   logic [4:0] fsel;
   logic selSw;
   logic selPrim;
   logic out0;
   logic oe0;

   assign fsel = ctrl[CT_FSEL +: 5];
   // on flash pins only select zero picks the flash path; user pins take any select but 5 and 31
   assign selPrim = ANY_PRIM ? (fsel != FN_SW && fsel != FN_NULL) : (fsel == FN_PRIM);
   assign selSw = fsel == FN_SW;
   assign out0 = selSw ? swOut : (selPrim & primOut);
   assign oe0 = selSw ? swOe : (selPrim & primOe);
   // data and enable through the mux
   assign padOut = ovr(out0, ctrl[CT_OUT +: 2]);
   assign padOe = ovr(oe0, ctrl[CT_OE +: 2]) & ~padCtl[PAD_OD];
   // input buffer gate, input always returned
   assign inSel = ovr(padIn & padCtl[PAD_IE], ctrl[CT_IN +: 2]);
endmodule

/* logic/gpio_irq_bank.sv */
// per-bank interrupt detection, edge latching and destination gating
module gpio_irq_bank
   import gpio_pkg::*;
#(
   parameter int N = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register side
   irq_bank_if.bank b
);
   localparam int W = (N + 7) / 8;
   localparam int RW = 32 * W;

   logic [N-1:0] prev_r;
   logic primed_r;
   logic [RW-1:0] edge_r;
   logic [RW-1:0] hit;
   logic [RW-1:0] lvl;
   logic [RW-1:0] valid;
   logic [RW-1:0] clr;
   logic [RW-1:0] en_r [NDEST];
   logic [RW-1:0] frc_r [NDEST];

   //==========================================================
   // detection
   always_comb begin
      hit = '0;
      lvl = '0;
      valid = '0;
      clr = '0;
      // nibble per pin, eight pins per word
      for (int i = 0; i < N; i++) begin
         lvl[4*i+IRQ_LOW] = ~b.level[i];
         lvl[4*i+IRQ_HIGH] = b.level[i];
         hit[4*i+IRQ_FALL] = primed_r & prev_r[i] & ~b.level[i];
         hit[4*i+IRQ_RISE] = primed_r & ~prev_r[i] & b.level[i];
         valid[4*i +: 4] = 4'hf;
      end
      for (int w = 0; w < W; w++) begin
         if (b.wrIntr && b.wrWord == 2'(w)) clr[32*w +: 32] = b.wrData;
      end
   end

   // first cycle after reset has no history, so no false edge
   always_ff @(posedge clk) begin
      if (rst) begin
         prev_r <= '0;
         primed_r <= 1'b0;
      end else begin
         prev_r <= b.level;
         primed_r <= 1'b1;
      end
   end

   // sticky edges, a new edge beats the clear
   always_ff @(posedge clk) begin
      if (rst) edge_r <= '0;
      else edge_r <= (edge_r & ~clr) | hit;
   end

   // enable and force words per destination
   always_ff @(posedge clk) begin
      for (int d = 0; d < NDEST; d++) begin
         for (int w = 0; w < W; w++) begin
            if (rst) begin
               en_r[d][32*w +: 32] <= '0;
               frc_r[d][32*w +: 32] <= '0;
            end else begin
               if (b.wrEn[d] && b.wrWord == 2'(w))
                  en_r[d][32*w +: 32] <= b.wrData & valid[32*w +: 32];
               if (b.wrForce[d] && b.wrWord == 2'(w))
                  frc_r[d][32*w +: 32] <= b.wrData & valid[32*w +: 32];
            end
         end
      end
   end

   // level bits straight from the pin
   assign b.raw = lvl | edge_r;
   assign b.edgeSet = |hit;

   // no flop between a level and the lines
   always_comb begin
      for (int d = 0; d < NDEST; d++) begin
         // raw or forced, gated by enable
         b.stat[d] = (b.raw | frc_r[d]) & en_r[d];
         b.line[d] = |b.stat[d];
         b.en[d] = en_r[d];
         b.frc[d] = frc_r[d];
      end
   end

   levelFollow_a: assert property (@(posedge clk) disable iff (rst)
      b.raw[IRQ_HIGH] == b.level[0] && b.raw[IRQ_LOW] == !b.level[0])
      else $error("level condition does not follow pin");
   edgeCatch_a: assert property (@(posedge clk) disable iff (rst)
      primed_r && prev_r[0] && !b.level[0] |=> b.raw[IRQ_FALL])
      else $error("falling edge not latched");
   edgeHold_a: assert property (@(posedge clk) disable iff (rst)
      b.raw[IRQ_RISE] && !(b.wrIntr && b.wrWord == 2'h0 && b.wrData[IRQ_RISE])
      |=> b.raw[IRQ_RISE])
      else $error("edge bit lost without clear");
   forceLine_a: assert property (@(posedge clk) disable iff (rst)
      $rose(frc_r[0][IRQ_RISE]) && en_r[0][IRQ_RISE] |-> b.line[0] && b.stat[0][IRQ_RISE])
      else $error("forced enabled condition not on line");
endmodule

/* tb/pin_world.sv */
// far-side pins: design drive, board drive, pulls, else floating
module pin_world
   import gpio_pkg::*;
(
   // clock
   input wire logic clk,
   // pad side of the design
   input wire logic [NPIN-1:0] padOut,
   input wire logic [NPIN-1:0] padOe,
   input wire logic [NPIN-1:0] padPullUp,
   input wire logic [NPIN-1:0] padPullDown,
   // board drivers
   input wire logic [NPIN-1:0] extOe,
   input wire logic [NPIN-1:0] extOut,
   output logic [NPIN-1:0] pinLvl
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [NPIN-1:0] lastLvl = '0;
   // pulls set undriven level
   // an undriven pin without pulls flips, so no lucky settled value
   assign pinLvl = (padOe & padOut) | (~padOe & extOe & extOut)
      | (~padOe & ~extOe & (padPullUp | (~padPullDown & ~lastLvl)));
   always_ff @(posedge clk) begin
      lastLvl <= pinLvl;
   end
endmodule

/* tb/tb_gpio_bank_irq_pad_mux.sv */
// self-checking bench of the gpio bank top
module tb_gpio_bank_irq_pad_mux
   import gpio_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err, irq;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic [NUSR-1:0] swOut = '0, swOe = '0, perOut = '0, perOe = '0, swIn, perIn;
   logic [NFL-1:0] swHiOut = '0, swHiOe = '0, flOut = '0, flOe = '0, swHiIn, flIn;
   logic [NPIN-1:0] extOe = '0, extOut = '0, padIn, padOut, padOe, padSlewFast;
   logic [NPIN-1:0] padSchmitt, padPullUp, padPullDown, padInEn;
   logic [2*NPIN-1:0] padDrive;
   logic [1:0] padLowVolt;
   logic [2*NDEST-1:0] irqLine;
   logic [5*NUSR-1:0] userFsel;
   int failures = 0, checkCount = 0;
   typedef struct {logic [11:0] a; logic [31:0] v;} row_s;
   row_s rows [7] = '{'{12'h004, 32'h1f}, '{12'h204, 32'h0}, '{12'h304, 32'h56},
      '{12'h384, 32'h56}, '{12'h300, 32'h0}, '{12'h100, 32'h0}, '{12'h3f4, 32'h0}};
   always #2.5 clk = ~clk;
   gpio_bank_irq_pad_mux dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .swOut, .swOe, .swIn, .perOut, .perOe, .perIn,
      .userFsel, .swHiOut, .swHiOe, .swHiIn, .flOut, .flOe, .flIn, .padIn, .padOut,
      .padOe, .padDrive, .padSlewFast, .padSchmitt, .padPullUp, .padPullDown, .padInEn,
      .padLowVolt, .irqLine, .irq);
   pin_world far (.clk, .padOut, .padOe, .padPullUp, .padPullDown, .extOe, .extOut,
      .pinLvl(padIn));
   //==========================================================
   // helpers
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checkCount++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // one more edge, so a write has landed before the caller looks
      @(posedge clk);
   endtask
   task automatic wrap_up;
      $display("checks %0d failures %0d", checkCount, failures);
      if (failures == 0 && checkCount > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      #100us;
      failures++;
      wrap_up();
   end
   //==========================================================
   // scenarios
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      foreach (rows[i]) begin
         apb(1'b0, rows[i].a, '0);
         check("reset value", rd, rows[i].v);
         check("reset error", {31'h0, err}, 32'h0);
      end
      check("input enables", padInEn[31:0], 32'hffffffff);
      check("fsel reset", {27'h0, userFsel[4:0]}, 32'h1f);
      flOut <= 6'h3f;
      flOe <= 6'h01;
      swHiOe <= 6'h01;
      extOe <= 36'h100000001;
      extOut <= 36'h100000000;
      repeat (2) @(posedge clk);
      check("flash drive", {30'h0, padOe[30], padOut[30]}, 32'h3);
      check("flash in", {20'h0, flIn, swHiIn}, 32'h145);
      apb(1'b1, 12'h204, 32'h5);
      check("sw drive", {30'h0, padOe[30], padOut[30]}, 32'h2);
      apb(1'b1, 12'h384, 32'hd6);
      check("output kill", {31'h0, padOe[30]}, 32'h0);
      apb(1'b1, 12'h304, 32'h3b);
      check("pad fields", {25'h0, padInEn[0], padDrive[1:0], padPullUp[0], padPullDown[0],
         padSchmitt[0], padSlewFast[0]}, 32'h3b);
      for (int d = 0; d < 4; d++) begin
         apb(1'b1, 12'h304, 32'h40 | (d << 4));
         check("drive", {30'h0, padDrive[1:0]}, 32'(d));
      end
      apb(1'b1, 12'h300, 32'h1);
      apb(1'b1, 12'h380, 32'h1);
      check("low volt", {30'h0, padLowVolt}, 32'h3);
      apb(1'b1, 12'h0f0, 32'hffffffff);
      apb(1'b1, 12'h100, 32'h8);
      apb(1'b1, 12'h160, 32'h1);
      apb(1'b1, 12'h234, 32'h200);
      apb(1'b1, 12'h3f4, 32'h1);
      apb(1'b0, 12'h3f0, '0);
      check("dormant low", {26'h0, irqLine}, 32'hc);
      extOut[0] <= 1'b1;
      repeat (3) @(posedge clk);
      check("lines rise", {29'h0, irq, irqLine[2], irqLine[0]}, 32'h5);
      check("user in", {30'h0, perIn[0], swIn[0]}, 32'h3);
      // idle pins 1..7 sit low, so their low-level bits show as well
      apb(1'b0, 12'h0f0, '0);
      check("raw rise", rd, 32'h1111111a);
      extOut[0] <= 1'b0;
      repeat (3) @(posedge clk);
      apb(1'b0, 12'h0f0, '0);
      check("raw latched", rd, 32'h1111111d);
      apb(1'b1, 12'h0f0, 32'hc);
      apb(1'b0, 12'h0f0, '0);
      check("raw cleared", {rd[30:0], irqLine[0]}, 32'h22222222);
      apb(1'b0, 12'h3f0, '0);
      check("event", rd, 32'h1);
      @(posedge clk);
      check("irq cleared", {31'h0, irq}, 32'h0);
      apb(1'b1, 12'h100, 32'hc);
      apb(1'b1, 12'h110, 32'h8);
      apb(1'b0, 12'h120, '0);
      check("forced status", {rd[30:0], irqLine[0]}, 32'h11);
      apb(1'b1, 12'h3f4, 32'h0);
      extOut[0] <= 1'b1;
      apb(1'b1, 12'h3f4, 32'h1);
      check("late mask", {31'h0, irq}, 32'h1);
      apb(1'b0, 12'h3f8, '0);
      check("unmapped", {rd[30:0], err}, 32'h1);
      wrap_up();
   end
endmodule
